// File: switch_table_indirect_access.sv
// Purpose: Switch side of indirect access: counters, static table, lookup
// Assumes: Host keeps one command at a time on the bus
// Notes: Data words are loaded in the cycle the command is taken
`timescale 1ns/10ps
module switch_table_indirect_access #(
	parameter int STATIC_ENTRIES = 8,
	parameter int MIB_PER_PORT = 32
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	indirect_bus_if.dev bus,
	input wire logic mib_event_in,
	input wire logic [6:0] mib_event_index_in,
	input wire logic [5:0] drop_event_in,
	input wire logic da_lookup_in,
	input wire logic [47:0] da_in,
	input wire logic [3:0] fid_in,
	input wire logic [1:0] ingress_port_in,
	input wire logic dyn_hit_in,
	input wire logic [2:0] dyn_ports_in,
	input wire logic [2:0] port_enable_in,
	output logic fwd_valid_out,
	output logic [2:0] fwd_ports_out,
	output logic fwd_static_out,
	output logic fwd_override_out
);
	localparam int MIB_TOTAL = table_access_pkg::NUM_PORTS * MIB_PER_PORT;
	localparam int EIDX_W = $clog2(STATIC_ENTRIES);

	if (MIB_PER_PORT > 32 || MIB_PER_PORT < 1 || STATIC_ENTRIES < 2 || STATIC_ENTRIES > 1024) begin : g_chk
		$error("Unsupported table size");
	end

	function automatic logic [6:0] flat_index(input logic [1:0] port, input logic [4:0] ctr);
		flat_index = 7'(int'(port) * MIB_PER_PORT + int'(ctr));
	endfunction

	function automatic logic [2:0] port_bit(input logic [1:0] port);
		port_bit = 3'(1 << port);
	endfunction

	logic [table_access_pkg::ENTRY_W-1:0] static_table [STATIC_ENTRIES];
	logic [table_access_pkg::MIB_VALUE_W-1:0] mib_count [MIB_TOTAL];
	logic mib_ovf [MIB_TOTAL];
	logic [15:0] drop_count [table_access_pkg::DROP_COUNTERS];
	logic [table_access_pkg::WORD3_W-1:0] word3;
	logic [15:0] word2;
	logic [15:0] word4;
	logic [15:0] word5;

	wire cmd_wr = bus.wr && bus.sel == table_access_pkg::SEL_CMD;
	wire cmd_read = bus.wdata[table_access_pkg::CMD_READ_BIT];
	wire [1:0] cmd_tbl = bus.wdata[table_access_pkg::CMD_TBL_HI:table_access_pkg::CMD_TBL_LO];
	wire [9:0] cmd_idx = bus.wdata[table_access_pkg::CMD_IDX_HI:0];
	wire static_rd = cmd_wr && cmd_read && cmd_tbl == table_access_pkg::TBL_STATIC;
	wire static_wr = cmd_wr && !cmd_read && cmd_tbl == table_access_pkg::TBL_STATIC;
	wire stat_rd = cmd_wr && cmd_read && cmd_tbl == table_access_pkg::TBL_MIB;
	wire [EIDX_W-1:0] entry_idx = cmd_idx[EIDX_W-1:0];
	wire entry_ok = int'(cmd_idx) < STATIC_ENTRIES;
	// drop counters above the extended offset
	wire is_drop = cmd_idx >= table_access_pkg::DROP_BASE;
	wire [9:0] drop_off = cmd_idx - table_access_pkg::DROP_BASE;
	wire [2:0] drop_sel = drop_off[2:0];
	wire drop_ok = int'(drop_off) < table_access_pkg::DROP_COUNTERS;
	// port field steps the offset by 0x20
	wire [1:0] mib_port = cmd_idx[table_access_pkg::PORT_STRIDE_LSB+1:table_access_pkg::PORT_STRIDE_LSB];
	wire [4:0] mib_ctr = cmd_idx[table_access_pkg::PORT_STRIDE_LSB-1:0];
	wire [6:0] mib_sel = flat_index(mib_port, mib_ctr);
	wire mib_ok = !is_drop && cmd_idx[9:7] == 3'h0 && int'(mib_port) < table_access_pkg::NUM_PORTS
		&& int'(mib_ctr) < MIB_PER_PORT;
	wire mib_clear = stat_rd && mib_ok;
	// entry assembled from the four data words
	wire [table_access_pkg::ENTRY_W-1:0] new_entry = {word3, word2, word5, word4};
	wire [table_access_pkg::ENTRY_W-1:0] old_entry = static_table[entry_idx];

	// Static table: only host writes change it, no aging path
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < STATIC_ENTRIES; i++) begin
				static_table[i] <= '0;
			end
		end else if (static_wr && entry_ok) begin
			static_table[entry_idx] <= new_entry;
		end
	end

	// cleared on read, new event still counted
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < MIB_TOTAL; i++) begin
				mib_count[i] <= '0;
				mib_ovf[i] <= 1'b0;
			end
		end else begin
			for (int i = 0; i < MIB_TOTAL; i++) begin
				if (mib_clear && int'(mib_sel) == i) begin
					mib_count[i] <= (mib_event_in && int'(mib_event_index_in) == i) ? 30'h1 : '0;
					mib_ovf[i] <= 1'b0;
				end else if (mib_event_in && int'(mib_event_index_in) == i) begin
					mib_count[i] <= mib_count[i] + 30'h1;
					mib_ovf[i] <= mib_ovf[i] | (&mib_count[i]);
				end
			end
		end
	end

	// plain 16-bit wrap, no overflow flag
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < table_access_pkg::DROP_COUNTERS; i++) begin
				drop_count[i] <= '0;
			end
		end else begin
			for (int i = 0; i < table_access_pkg::DROP_COUNTERS; i++) begin
				if (drop_event_in[i]) begin
					drop_count[i] <= drop_count[i] + 16'h0001;
				end
			end
		end
	end

	// Data words: host writes, or loads by read command
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			word2 <= '0;
			word3 <= '0;
			word4 <= '0;
			word5 <= '0;
		end else if (bus.wr && bus.sel == table_access_pkg::SEL_WORD2) begin
			word2 <= bus.wdata;
		end else if (bus.wr && bus.sel == table_access_pkg::SEL_WORD3) begin
			word3 <= bus.wdata[table_access_pkg::WORD3_W-1:0];
		end else if (bus.wr && bus.sel == table_access_pkg::SEL_WORD4) begin
			word4 <= bus.wdata;
		end else if (bus.wr && bus.sel == table_access_pkg::SEL_WORD5) begin
			word5 <= bus.wdata;
		end else if (static_rd) begin
			// entry split over words 3, 2, 5, 4
			{word3, word2, word5, word4} <= entry_ok ? old_entry : '0;
		end else if (stat_rd && is_drop) begin
			// drop value in word four only
			word4 <= drop_ok ? drop_count[drop_sel] : '0;
		end else if (stat_rd) begin
			word5 <= mib_ok ? {mib_ovf[mib_sel], 1'b1, mib_count[mib_sel][29:16]} : '0;
			word4 <= mib_ok ? mib_count[mib_sel][15:0] : '0;
		end
	end

	// Read port: answer one cycle after the strobe
	wire [15:0] read_mux = bus.sel == table_access_pkg::SEL_WORD2 ? word2
		: bus.sel == table_access_pkg::SEL_WORD3 ? 16'(word3)
		: bus.sel == table_access_pkg::SEL_WORD4 ? word4
		: bus.sel == table_access_pkg::SEL_WORD5 ? word5 : 16'h0000;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bus.rdata <= '0;
			bus.rvalid <= 1'b0;
		end else begin
			bus.rdata <= bus.rd ? read_mux : bus.rdata;
			bus.rvalid <= bus.rd;
		end
	end

	// Static destination search, lowest index wins
	logic hit;
	logic [EIDX_W-1:0] hit_idx;
	always_comb begin
		hit = 1'b0;
		hit_idx = '0;
		for (int i = STATIC_ENTRIES - 1; i >= 0; i--) begin
			// filter group joins the match when selected
			if ((static_table[i][table_access_pkg::VALID_BIT]
				|| static_table[i][table_access_pkg::OVERRIDE_BIT])
				&& static_table[i][table_access_pkg::MAC_HI:0] == da_in
				&& (!static_table[i][table_access_pkg::USE_FID_BIT]
				|| static_table[i][table_access_pkg::FID_HI:table_access_pkg::FID_LO] == fid_in)) begin
				hit = 1'b1;
				hit_idx = EIDX_W'(i);
			end
		end
	end

	wire [table_access_pkg::ENTRY_W-1:0] hit_entry = static_table[hit_idx];
	wire hit_override = hit && hit_entry[table_access_pkg::OVERRIDE_BIT];
	wire [2:0] hit_mask = hit_entry[table_access_pkg::FWD_HI:table_access_pkg::FWD_LO];
	// all ones means every port but ingress
	wire [2:0] static_mask = hit_mask == table_access_pkg::PORTS_ALL
		? ~port_bit(ingress_port_in) : hit_mask;
	// dynamic result from the caller's search
	wire [2:0] raw_mask = hit ? static_mask : (dyn_hit_in ? dyn_ports_in : 3'h0);
	wire rx_ok = (port_enable_in & port_bit(ingress_port_in)) != 3'h0;
	wire [2:0] final_mask = hit_override ? raw_mask : (rx_ok ? raw_mask & port_enable_in : 3'h0);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fwd_valid_out <= 1'b0;
			fwd_ports_out <= '0;
			fwd_static_out <= 1'b0;
			fwd_override_out <= 1'b0;
		end else begin
			fwd_valid_out <= da_lookup_in;
			fwd_ports_out <= da_lookup_in ? final_mask : fwd_ports_out;
			fwd_static_out <= da_lookup_in && hit;
			fwd_override_out <= da_lookup_in && hit_override;
		end
	end
endmodule

// File: table_access_pkg.sv
// Purpose: Shared constants for the switch indirect table access ends
// Assumes: Both ends run on one 25 MHz clock
// Notes: Command word is read flag, table select, ten-bit index
package table_access_pkg;
	localparam int CMD_READ_BIT = 12;
	localparam int CMD_TBL_HI = 11;
	localparam int CMD_TBL_LO = 10;
	localparam int CMD_IDX_HI = 9;
	localparam logic [1:0] TBL_STATIC = 2'h0;
	localparam logic [1:0] TBL_DYNAMIC = 2'h2;
	localparam logic [1:0] TBL_MIB = 2'h3;
	localparam logic [9:0] DROP_BASE = 10'h100;
	localparam logic [9:0] RX_DROP_BASE = 10'h103;
	localparam int DROP_COUNTERS = 6;
	localparam int PORT_STRIDE_LSB = 5;
	localparam int NUM_PORTS = 3;
	localparam int MIB_VALUE_W = 30;
	localparam int MIB_OVF_BIT = 15;
	localparam int MIB_VALID_BIT = 14;
	localparam int ENTRY_W = 58;
	localparam int FID_HI = 57;
	localparam int FID_LO = 54;
	localparam int USE_FID_BIT = 53;
	localparam int OVERRIDE_BIT = 52;
	localparam int VALID_BIT = 51;
	localparam int FWD_HI = 50;
	localparam int FWD_LO = 48;
	localparam int MAC_HI = 47;
	localparam int WORD3_W = 10;
	localparam logic [2:0] SEL_CMD = 3'h0;
	localparam logic [2:0] SEL_WORD2 = 3'h2;
	localparam logic [2:0] SEL_WORD3 = 3'h3;
	localparam logic [2:0] SEL_WORD4 = 3'h4;
	localparam logic [2:0] SEL_WORD5 = 3'h5;
	localparam logic [2:0] PORTS_ALL = 3'h7;
	localparam logic [1:0] OP_MIB_READ = 2'h0;
	localparam logic [1:0] OP_DROP_READ = 2'h1;
	localparam logic [1:0] OP_STATIC_READ = 2'h2;
	localparam logic [1:0] OP_STATIC_WRITE = 2'h3;
endpackage

// File: indirect_bus_if.sv
// Purpose: Host register bus joining the two ends
// Assumes: Both ends on the same clock
// Notes: One-cycle strobes, read answer one cycle later
`timescale 1ns/10ps
interface indirect_bus_if;
	logic [2:0] sel;
	logic wr;
	logic rd;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic rvalid;
	modport host (output sel, output wr, output rd, output wdata, input rdata, input rvalid);
	modport dev (input sel, input wr, input rd, input wdata, output rdata, output rvalid);
endinterface

// File: switch_table_host.sv
// Purpose: Host side: runs indirect sequences over the register bus
// Assumes: One request at a time, start taken only when idle
// Notes: Result words are shifted in high part first
`timescale 1ns/10ps
module switch_table_host (
	input wire logic clk_in,
	input wire logic rst_b_in,
	indirect_bus_if.host bus,
	input wire logic start_in,
	input wire logic [1:0] op_in,
	input wire logic [9:0] index_in,
	input wire logic [57:0] entry_in,
	output logic busy_out,
	output logic done_out,
	output logic [57:0] result_out
);
	typedef enum logic [2:0] {IDLE, FILL, COMMAND, ISSUE, WAIT} state_t;
	state_t state;
	logic [1:0] op;
	logic [9:0] index;
	logic [57:0] entry;
	logic [1:0] step;
	logic [63:0] shift;

	// read order 3, 2, 5, 4
	function automatic logic [2:0] word_of(input logic [1:0] kind, input logic [1:0] s);
		if (kind == table_access_pkg::OP_STATIC_READ || kind == table_access_pkg::OP_STATIC_WRITE) begin
			word_of = s == 2'h0 ? table_access_pkg::SEL_WORD3 : s == 2'h1 ? table_access_pkg::SEL_WORD2
				: s == 2'h2 ? table_access_pkg::SEL_WORD5 : table_access_pkg::SEL_WORD4;
		end else if (kind == table_access_pkg::OP_MIB_READ && s == 2'h0) begin
			word_of = table_access_pkg::SEL_WORD5;
		end else begin
			word_of = table_access_pkg::SEL_WORD4;
		end
	endfunction

	wire [1:0] last_step = op == table_access_pkg::OP_MIB_READ ? 2'h1
		: op == table_access_pkg::OP_DROP_READ ? 2'h0 : 2'h3;
	wire [2:0] cur_word = word_of(op, step);
	wire [15:0] fill_data = step == 2'h0 ? 16'(entry[57:48]) : step == 2'h1 ? entry[47:32]
		: step == 2'h2 ? entry[31:16] : entry[15:0];
	wire [1:0] tbl = op == table_access_pkg::OP_MIB_READ || op == table_access_pkg::OP_DROP_READ
		? table_access_pkg::TBL_MIB : table_access_pkg::TBL_STATIC;
	wire [15:0] cmd_word = {3'h0, op != table_access_pkg::OP_STATIC_WRITE, tbl, index};
	// bit 30 clear means read word five again
	wire not_ready = op == table_access_pkg::OP_MIB_READ && step == 2'h0
		&& !bus.rdata[table_access_pkg::MIB_VALID_BIT];

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state <= IDLE;
			op <= '0;
			index <= '0;
			entry <= '0;
			step <= '0;
			shift <= '0;
			bus.sel <= '0;
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			bus.wdata <= '0;
			busy_out <= 1'b0;
			done_out <= 1'b0;
			result_out <= '0;
		end else begin
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			done_out <= 1'b0;
			unique case (state)
				IDLE: begin
					if (start_in) begin
						op <= op_in;
						index <= index_in;
						entry <= entry_in;
						step <= '0;
						shift <= '0;
						busy_out <= 1'b1;
						state <= op_in == table_access_pkg::OP_STATIC_WRITE ? FILL : COMMAND;
					end
				end
				FILL: begin
					bus.wr <= 1'b1;
					bus.sel <= cur_word;
					bus.wdata <= fill_data;
					step <= step + 2'h1;
					state <= step == 2'h3 ? COMMAND : FILL;
				end
				COMMAND: begin
					bus.wr <= 1'b1;
					bus.sel <= table_access_pkg::SEL_CMD;
					bus.wdata <= cmd_word;
					step <= '0;
					state <= op == table_access_pkg::OP_STATIC_WRITE ? IDLE : ISSUE;
					busy_out <= op != table_access_pkg::OP_STATIC_WRITE;
					done_out <= op == table_access_pkg::OP_STATIC_WRITE;
				end
				ISSUE: begin
					bus.rd <= 1'b1;
					bus.sel <= cur_word;
					state <= WAIT;
				end
				WAIT: begin
					if (bus.rvalid) begin
						if (not_ready) begin
							state <= ISSUE;
						end else if (step == last_step) begin
							result_out <= 58'({shift[47:0], bus.rdata});
							busy_out <= 1'b0;
							done_out <= 1'b1;
							state <= IDLE;
						end else begin
							shift <= {shift[47:0], bus.rdata};
							step <= step + 2'h1;
							state <= ISSUE;
						end
					end
				end
			endcase
		end
	end
endmodule

// File: switch_table_indirect_access_properties.sv
// Purpose: Bus-level checks between host and switch ends of indirect access
// Assumes: Single clock domain, async active-low reset
// Notes: Sees only the shared bus signals
`timescale 1ns/10ps
module switch_table_indirect_access_properties (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [2:0] sel,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic rvalid
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);
	sequence mib_cmd;
		wr && sel == 3'h0 && wdata[12:8] == 5'h1c;
	endsequence
	sequence drop_cmd;
		wr && sel == 3'h0 && wdata[12:8] == 5'h1d;
	endsequence
	sequence st_rd_cmd;
		wr && sel == 3'h0 && wdata[12:10] == 3'h4;
	endsequence
	sequence upper_rd;
		rd && sel == 3'h5;
	endsequence
	sequence st_fill;
		wr && sel == 3'h3 ##1 wr && sel == 3'h2 ##1 wr && sel == 3'h5 ##1 wr && sel == 3'h4;
	endsequence
	a_read_answer: assert property (rd |=> rvalid)
		else $error("read strobe without answer next cycle");
	a_answer_cause: assert property (rvalid |-> $past(rd))
		else $error("read answer without read strobe");
	a_single_strobe: assert property (!(wr && rd))
		else $error("write and read strobes together");
	a_rdata_hold: assert property (!rvalid |-> $stable(rdata))
		else $error("read data changed without answer");
	a_mib_upper_first: assert property (mib_cmd |=> upper_rd)
		else $error("counter command not followed by upper word read");
	a_mib_valid_flag: assert property (mib_cmd ##1 upper_rd |=> rvalid && rdata[14])
		else $error("counter upper word without valid flag");
	a_mib_lower_next: assert property (mib_cmd ##1 upper_rd ##1 rvalid |=> ##1 rd && sel == 3'h4)
		else $error("lower counter word not read after upper");
	a_drop_word_four: assert property (drop_cmd |=> rd && sel == 3'h4)
		else $error("drop counter not read from word four");
	a_static_rd_order: assert property (st_rd_cmd |=> rd && sel == 3'h3 ##3 rd && sel == 3'h2
		##3 rd && sel == 3'h5 ##3 rd && sel == 3'h4)
		else $error("static read words out of order");
	a_fid_top_only: assert property (st_rd_cmd ##1 rd && sel == 3'h3 |=> rdata[15:10] == 6'h00)
		else $error("static word three has bits above entry");
	a_static_wr_cmd: assert property (st_fill |=> wr && sel == 3'h0 && wdata[12:10] == 3'h0)
		else $error("static fill not followed by write command");
endmodule

// File: tb_switch_table_indirect_access.sv
// Purpose: Self-checking bench for host and switch ends joined by the bus
// Assumes: Inputs driven at falling edge, results queued by the driver
// Notes: Random addresses from an xorshift generator
`timescale 1ns/10ps
module tb_switch_table_indirect_access;
	logic clk_in = 0, rst_b_in = 0, start_in = 0, mib_event_in = 0, da_lookup_in = 0, dyn_hit_in = 0;
	logic [1:0] op_in = 0, ingress_port_in = 0;
	logic [9:0] index_in = 0;
	logic [57:0] entry_in = 0;
	logic [6:0] mib_event_index_in = 0;
	logic [5:0] drop_event_in = 0;
	logic [47:0] da_in = 0;
	logic [3:0] fid_in = 0;
	logic [2:0] dyn_ports_in = 0, port_enable_in = 3'h7;
	wire busy_out, done_out, fwd_valid_out, fwd_static_out, fwd_override_out;
	wire [57:0] result_out;
	wire [2:0] fwd_ports_out;
	int error_cnt = 0, checks = 0;
	logic [31:0] seed = 32'h0000_004e;
	logic [115:0] res_q[$];
	logic [4:0] fwd_q[$];
	logic [47:0] mac[8];
	logic [57:0] ent[8];
	indirect_bus_if bus_if ();
	switch_table_indirect_access i_switch_table_indirect_access (.clk_in(clk_in),
		.rst_b_in(rst_b_in), .bus(bus_if), .mib_event_in(mib_event_in),
		.mib_event_index_in(mib_event_index_in), .drop_event_in(drop_event_in),
		.da_lookup_in(da_lookup_in), .da_in(da_in), .fid_in(fid_in),
		.ingress_port_in(ingress_port_in), .dyn_hit_in(dyn_hit_in), .dyn_ports_in(dyn_ports_in),
		.port_enable_in(port_enable_in), .fwd_valid_out(fwd_valid_out),
		.fwd_ports_out(fwd_ports_out), .fwd_static_out(fwd_static_out),
		.fwd_override_out(fwd_override_out));
	switch_table_host i_switch_table_host (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus(bus_if),
		.start_in(start_in), .op_in(op_in), .index_in(index_in), .entry_in(entry_in),
		.busy_out(busy_out), .done_out(done_out), .result_out(result_out));
	switch_table_indirect_access_properties i_switch_table_indirect_access_properties (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .sel(bus_if.sel), .wr(bus_if.wr), .rd(bus_if.rd),
		.wdata(bus_if.wdata), .rdata(bus_if.rdata), .rvalid(bus_if.rvalid));
	initial begin
		forever #20 clk_in = ~clk_in;
	end
	task automatic chk(input string name, input logic [57:0] seen, input logic [57:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task tally_and_finish;
		if (error_cnt == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	function automatic logic [47:0] rnd48();
		logic [47:0] r;
		r = 0;
		for (int k = 0; k < 2; k++) begin
			seed ^= seed << 13;
			seed ^= seed >> 17;
			seed ^= seed << 5;
			r = {r[23:0], seed[23:0]};
		end
		return r;
	endfunction
	task automatic run_op(input logic [1:0] o, input logic [9:0] idx, input logic [57:0] wr_ent,
		input logic [57:0] exp, input logic [57:0] msk);
		int n;
		@(negedge clk_in);
		start_in = 1;
		op_in = o;
		index_in = idx;
		entry_in = wr_ent;
		res_q.push_back({msk, exp});
		@(negedge clk_in);
		start_in = 0;
		for (n = 0; n < 200 && busy_out !== 1'b0; n++) @(negedge clk_in);
		@(negedge clk_in);
	endtask
	task automatic look(input logic [47:0] da, input logic [3:0] filter_group_id, input logic [1:0] ing,
		input logic [2:0] pe, input logic [4:0] exp);
		@(negedge clk_in);
		da_lookup_in = 1;
		da_in = da;
		fid_in = filter_group_id;
		ingress_port_in = ing;
		port_enable_in = pe;
		dyn_hit_in = 1;
		dyn_ports_in = 3'h4;
		fwd_q.push_back(exp);
		@(negedge clk_in);
		da_lookup_in = 0;
	endtask
	always @(negedge clk_in) begin
		logic [115:0] e;
		logic [4:0] f;
		if (done_out === 1'b1) begin
			e = (res_q.size() > 0) ? res_q.pop_front() : '1;
			chk("result", result_out & e[115:58], e[57:0]);
		end
		if (fwd_valid_out === 1'b1) begin
			f = (fwd_q.size() > 0) ? fwd_q.pop_front() : 5'h1f;
			chk("forward", {53'h0, fwd_ports_out, fwd_static_out, fwd_override_out}, {53'h0, f});
		end
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		error_cnt++;
		tally_and_finish;
	end
	initial begin
		repeat (3) @(posedge clk_in);
		@(negedge clk_in);
		rst_b_in = 1;
		for (int i = 0; i < 8; i++) mac[i] = rnd48();
		// Fields: group id, group-match, override, valid, ports, address
		ent[7] = {4'h5, 3'h5, 3'h3, mac[7]};
		ent[6] = {4'h0, 3'h0, 3'h1, mac[6]};
		ent[5] = {4'h0, 3'h2, 3'h7, mac[5]};
		ent[4] = {4'h9, 3'h1, 3'h7, mac[4]};
		for (int i = 4; i < 8; i++) run_op(2'h3, 10'(i), ent[i], 58'h0, 58'h0);
		for (int i = 4; i < 8; i++) run_op(2'h2, 10'(i), 58'h0, ent[i], {58{1'b1}});
		run_op(2'h2, 10'h008, 58'h0, 58'h0, {58{1'b1}});
		// static beats dynamic, group must match
		look(mac[7], 4'h5, 2'h0, 3'h7, {3'h3, 2'h2});
		look(mac[7], 4'h6, 2'h0, 3'h7, {3'h4, 2'h0});
		look(mac[6], 4'h0, 2'h0, 3'h7, {3'h4, 2'h0});
		look(mac[5], 4'h3, 2'h0, 3'h1, {3'h6, 2'h3});
		// broadcast minus ingress, masked by enables
		look(mac[4], 4'hb, 2'h1, 3'h3, {3'h1, 2'h2});
		look(mac[7], 4'h5, 2'h0, 3'h6, {3'h0, 2'h2});
		@(negedge clk_in);
		mib_event_in = 1;
		mib_event_index_in = 7'h0e;
		repeat (5) @(negedge clk_in);
		mib_event_index_in = 7'h2e;
		repeat (3) @(negedge clk_in);
		mib_event_in = 0;
		run_op(2'h0, 10'h00e, 58'h0, 58'h00_4000_0005, 58'h00_ffff_ffff);
		run_op(2'h0, 10'h00e, 58'h0, 58'h00_4000_0000, 58'h00_ffff_ffff);
		run_op(2'h0, 10'h02e, 58'h0, 58'h00_4000_0003, 58'h00_ffff_ffff);
		for (int i = 0; i < 6; i++) begin
			@(negedge clk_in);
			drop_event_in = 6'h01 << i;
			repeat (i + 1) @(negedge clk_in);
			drop_event_in = 6'h00;
			repeat (2) run_op(2'h1, table_access_pkg::DROP_BASE + 10'(i), 58'h0, 58'(i + 1),
				58'h00_0000_ffff);
		end
		repeat (4) @(negedge clk_in);
		chk("pending", 58'(res_q.size() + fwd_q.size()), 58'h0);
		tally_and_finish;
	end
endmodule
